// ===== sys_align_defines.vh
// Register map, field positions and reset values of the system alignment and update control block
`ifndef SYS_ALIGN_DEFINES_VH
`define SYS_ALIGN_DEFINES_VH

// ----------------------------------------
// Register addresses (12-bit register space)
// ----------------------------------------
`define ADDR_SYSTEM_CONTROL 12'h230
`define ADDR_COMMIT_STROBE 12'h232
`define ADDR_SEG_FIRST 12'hA00
`define ADDR_SEG_LAST 12'hA16
`define SEG_COUNT 23

// ----------------------------------------
// System control fields
// ----------------------------------------
`define BIT_ANTIRUNT_DIS 3
`define BIT_ALIGN_PD 2
`define BIT_DISTREF_PD 1
`define BIT_SOFT_ALIGN 0
`define SYSCTL_RESET 8'h00
`define SYSCTL_MASK 8'h0F
`define BIT_COMMIT 0

// ----------------------------------------
// Segment list opcodes and defaults
// ----------------------------------------
`define SEG_OP_COMMIT 8'h80
`define SEG_OP_END 8'hFF
`define SEG_ZERO 8'h00

`endif

// ===== seg_list_defaults.v
// Reset default table of the nonvolatile-memory segment list
`timescale 1ns/10ps
`default_nettype none
`include "sys_align_defines.vh"

module seg_list_defaults (
    input wire [4:0] index,    // Segment entry index
    output reg [7:0] value     // Default byte for that entry
);
    // Default list: one segment, byte count 0x00FF from start address 0x0000, then commit and end
    always @* begin
        case (index)
            5'h00: value = 8'h00;           // Byte count high
            5'h01: value = 8'hFF;           // Byte count low
            5'h02: value = 8'h00;           // Start address high
            5'h03: value = 8'h00;           // Start address low
            5'h04: value = `SEG_OP_COMMIT;
            5'h05: value = `SEG_OP_END;
            default: value = `SEG_ZERO;
        endcase
    end
endmodule
`default_nettype wire

// ===== system_align_update_control.v
// System control, commit strobe and segment list registers on the serial port clock
`timescale 1ns/10ps
`default_nettype none
`include "sys_align_defines.vh"

module system_align_update_control #(
    parameter SEGS = `SEG_COUNT     // Number of segment list entries
) (
    input wire mclk,                // Serial port clock
    input wire rst,                 // Asynchronous reset, active high
    input wire wrEn,                // Register write strobe
    input wire rdEn,                // Register read strobe
    input wire [11:0] addr,         // Register address
    input wire [7:0] wrData,        // Write data
    output reg [7:0] rdData,        // Read data, registered
    input wire alignPin,            // Alignment pin, asynchronous, active low
    input wire nvmCommitReq,        // Commit request from memory controller
    input wire [4:0] segIndex,      // Segment entry index from memory controller
    output reg [7:0] segData,       // Segment entry to memory controller
    output reg antiRuntDis,         // Active anti-runt disable
    output reg alignPd,             // Active alignment power-down
    output reg distRefPd,           // Active distribution reference power-down
    output reg outputsStatic,       // Selected channels held static
    output reg alignEvent,          // One-cycle alignment trigger
    output reg commitDone           // One-cycle pulse after a commit
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [7:0] sysBuf_r;
    reg [7:0] sysAct_r;
    reg commit_r;
    reg pinMeta_r;
    reg pinSync_r;
    reg alignReq_r;
    reg alignReqPrev_r;
    reg [7:0] seg_r [0:SEGS-1];
    reg segInit_r;
    reg [7:0] rdData_nxt;
    wire sysHit;
    wire commitHit;
    wire segHit;
    wire [11:0] segOff;
    wire alignReqNxt;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    assign sysHit = (addr == `ADDR_SYSTEM_CONTROL);
    assign commitHit = (addr == `ADDR_COMMIT_STROBE);
    assign segHit = (addr >= `ADDR_SEG_FIRST) && (addr <= `ADDR_SEG_LAST);
    assign segOff = addr - `ADDR_SEG_FIRST;

    // ----------------------------------------
    // Buffer register and commit strobe
    // ----------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sysBuf_r <= `SYSCTL_RESET;
        end else if (wrEn && sysHit) begin
            sysBuf_r <= wrData & `SYSCTL_MASK;
        end
    end

    // Strobe lives one cycle, so software never has to clear it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            commit_r <= 1'b0;
        end else begin
            commit_r <= (wrEn && commitHit && wrData[`BIT_COMMIT]) || nvmCommitReq;
        end
    end

    // Whole active set loads in one edge, so no mixed settings appear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sysAct_r <= `SYSCTL_RESET;
            commitDone <= 1'b0;
        end else begin
            commitDone <= commit_r;
            if (commit_r) begin
                sysAct_r <= sysBuf_r;
            end
        end
    end

    // ----------------------------------------
    // Active controls
    // ----------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            antiRuntDis <= 1'b0;
            alignPd <= 1'b0;
            distRefPd <= 1'b0;
        end else begin
            antiRuntDis <= sysAct_r[`BIT_ANTIRUNT_DIS];
            alignPd <= sysAct_r[`BIT_ALIGN_PD];
            distRefPd <= sysAct_r[`BIT_DISTREF_PD];
        end
    end

    // ----------------------------------------
    // Alignment: pin low or soft bit high holds outputs while the active alignment power-down bit is clear
    // ----------------------------------------
    // Preset to the idle pin level, so reset release gives no false edge
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= 1'b1;
            pinSync_r <= 1'b1;
        end else begin
            pinMeta_r <= alignPin;
            pinSync_r <= pinMeta_r;
        end
    end

    // Soft bit is the pin with inverted polarity
    assign alignReqNxt = (sysAct_r[`BIT_SOFT_ALIGN] || !pinSync_r) && !sysAct_r[`BIT_ALIGN_PD];

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            alignReq_r <= 1'b0;
            alignReqPrev_r <= 1'b0;
            outputsStatic <= 1'b0;
            alignEvent <= 1'b0;
        end else begin
            alignReq_r <= alignReqNxt;
            alignReqPrev_r <= alignReq_r;
            outputsStatic <= alignReq_r;
            alignEvent <= alignReqPrev_r && !alignReq_r;
        end
    end

    // ----------------------------------------
    // Segment list storage
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < SEGS; g = g + 1) begin : segEntry
            wire [31:0] entryNum;
            wire [7:0] defVal;
            assign entryNum = g;
            seg_list_defaults defTab (
                .index(entryNum[4:0]),
                .value(defVal)
            );
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    seg_r[g] <= `SEG_ZERO;
                end else if (wrEn && segHit && segOff == entryNum[11:0]) begin
                    seg_r[g] <= wrData;
                end else if (segInit_r) begin
                    seg_r[g] <= defVal;
                end
            end
        end
    endgenerate

    // Defaults load on the first edge after reset release
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            segInit_r <= 1'b1;
        end else begin
            segInit_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Segment list readout
    // ----------------------------------------
    // Past the last entry the controller reads an end marker
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            segData <= `SEG_ZERO;
        end else if (segIndex < SEGS) begin
            segData <= seg_r[segIndex];
        end else begin
            segData <= `SEG_OP_END;
        end
    end

    // ----------------------------------------
    // Read back: buffer view of system control
    // ----------------------------------------
    always @* begin
        rdData_nxt = rdData;
        if (rdEn) begin
            if (sysHit) begin
                rdData_nxt = sysBuf_r;
            end else if (commitHit) begin
                rdData_nxt = {7'h00, commit_r};
            end else if (segHit) begin
                rdData_nxt = seg_r[segOff[4:0]];
            end else begin
                rdData_nxt = `SEG_ZERO;
            end
        end
    end

    // Read data stands until the next read strobe
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData <= `SEG_ZERO;
        end else begin
            rdData <= rdData_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== system_align_update_control_chk.sv
// Assertions on the ports of the system alignment and update control block
`timescale 1ns/10ps
`default_nettype none
module system_align_update_control_chk #(
    parameter SEGS = 23                // Segment entries
) (
    input wire logic mclk,             // Clock
    input wire logic rst,              // Reset
    input wire logic wrEn,             // Write strobe
    input wire logic rdEn,             // Read strobe
    input wire logic [11:0] addr,      // Address
    input wire logic [7:0] wrData,     // Write data
    input wire logic [7:0] rdData,     // Read data
    input wire logic [4:0] segIndex,   // Entry index
    input wire logic [7:0] segData,    // Entry data
    input wire logic antiRuntDis,      // Active bit 3
    input wire logic alignPd,          // Active bit 2
    input wire logic distRefPd,        // Active bit 1
    input wire logic outputsStatic,    // Channels static
    input wire logic alignEvent,       // Alignment pulse
    input wire logic commitDone        // Commit pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence commitWr;
        wrEn && addr == 12'h232 && wrData[0];
    endsequence
    sequence doneLater;
        ##2 commitDone;
    endsequence
    chk_commit_latency: assert property (commitWr |-> doneLater) else $error("commit not done");
    chk_commit_clear: assert property (commitDone |=> !commitDone) else $error("commit stuck");
    chk_active_atomic: assert property ($changed({antiRuntDis, alignPd, distRefPd}) |-> $past(commitDone))
        else $error("active bits moved alone");
    chk_event_pulse: assert property (alignEvent |=> !alignEvent) else $error("event too long");
    chk_event_fall: assert property (alignEvent |-> $fell(outputsStatic)) else $error("stray event");
    chk_static_pd: assert property ($rose(outputsStatic) |-> !alignPd) else $error("static while off");
    chk_sysctl_upper: assert property (rdEn && addr == 12'h230 |=> rdData[7:4] == 4'h0)
        else $error("upper bits set");
    chk_seg_beyond: assert property (segIndex >= SEGS |=> segData == 8'hFF) else $error("bad end entry");
endmodule
bind system_align_update_control system_align_update_control_chk #(.SEGS(SEGS)) i_chk (.mclk, .rst, .wrEn,
    .rdEn, .addr, .wrData, .rdData, .segIndex, .segData, .antiRuntDis, .alignPd, .distRefPd, .outputsStatic,
    .alignEvent, .commitDone);
`default_nettype wire

// ===== system_align_update_control_tb.sv
// Self-checking bench for the system alignment and update control block
`timescale 1ns/10ps
`default_nettype none
module system_align_update_control_tb;
    logic mclk = 0, rst = 1, wrEn = 0, rdEn = 0, alignPin = 1, nvmCommitReq = 0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wrData = 8'h00;
    logic [4:0] segIndex = 5'h00;
    wire [7:0] rdData, segData;
    wire antiRuntDis, alignPd, distRefPd, outputsStatic, alignEvent, commitDone;
    wire [2:0] flags = {outputsStatic, alignEvent, commitDone};
    int fail_count = 0, num_checks = 0;
    always #10 mclk = ~mclk;
    system_align_update_control i_system_align_update_control (.mclk, .rst, .wrEn, .rdEn, .addr, .wrData,
        .rdData, .alignPin, .nvmCommitReq, .segIndex, .segData, .antiRuntDis, .alignPd, .distRefPd,
        .outputsStatic, .alignEvent, .commitDone);
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wrData = d;
        wrEn = 1;
        @(posedge mclk);
        #1 wrEn = 0;
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        addr = a;
        rdEn = 1;
        @(posedge mclk);
        #1 rdEn = 0;
        chk(rdData, exp);
        @(posedge mclk);
        #1;
    endtask
    // Bounded wait for one of the status flags
    task automatic waitHi(input int s);
        int n;
        n = 0;
        while (n < 20 && flags[s] !== 1'b1) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(flags[s], 8'h01);
    endtask
    task automatic commit;
        wr(12'h232, 8'h01);
        waitHi(0);
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        print_verdict;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        #1 rst = 0;
        repeat (2) @(posedge mclk);
        #1 chk({antiRuntDis, alignPd, distRefPd, outputsStatic}, 8'h00);
        rd(12'h230, 8'h00);
        for (int i = 0; i < 23; i++)
            rd(12'hA00 + 12'(i), (i == 1 || i == 5) ? 8'hFF : (i == 4) ? 8'h80 : 8'h00);
        for (int i = 21; i < 26; i++) begin
            segIndex = 5'(i);
            @(posedge mclk);
            #1 chk(segData, (i < 23) ? 8'h00 : 8'hFF);
        end
        wr(12'hA03, 8'h5A);
        rd(12'hA03, 8'h5A);
        rd(12'hA17, 8'h00);
        wr(12'h230, 8'hFE);
        repeat (6) @(posedge mclk);
        #1 chk(antiRuntDis, 8'h00);
        rd(12'h230, 8'h0E);
        commit;
        @(posedge mclk);
        #1 chk({antiRuntDis, alignPd, distRefPd}, 8'h07);
        rd(12'h232, 8'h00);
        // Mid-run reset must drop the active levels at once
        rst = 1;
        #5 chk({antiRuntDis, alignPd, distRefPd}, 8'h00);
        @(posedge mclk);
        #1 rst = 0;
        repeat (2) @(posedge mclk);
        #1 wr(12'h230, 8'h01);
        commit;
        waitHi(2);
        wr(12'h230, 8'h00);
        commit;
        waitHi(1);
        alignPin = 0;
        waitHi(2);
        alignPin = 1;
        waitHi(1);
        nvmCommitReq = 1;
        @(posedge mclk);
        #1 nvmCommitReq = 0;
        waitHi(0);
        print_verdict;
    end
endmodule
`default_nettype wire
